// file: flk_pkg.sv
// Constants and types shared by the flash lock and status controller
package flk_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // Controller register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] ADDR_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  localparam logic [3:0] WP_OFS = 4'hc;
  localparam int CTRL_GO_BIT = 4;
  localparam int STAT_BUSY_BIT = 31;
  localparam int STAT_LOCK_LSB = 8;

  // Flash command codes
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK = 8'h01;
  localparam logic [7:0] CMD_UNLOCK = 8'hd0;
  localparam logic [7:0] CMD_LOCKDOWN = 8'h2f;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [ADDR_W-1:0] LOCK_STAT_OFS = 22'h000002;

  // Field positions of the operation status word
  localparam int SR_ENGINE_READY = 7;
  localparam int SR_ERASE_PAUSED = 6;
  localparam int SR_ERASE_FAIL = 5;
  localparam int SR_PROGRAM_FAIL = 4;
  localparam int SR_SUPPLY_LOW = 3;
  localparam int SR_PROGRAM_PAUSED = 2;
  localparam int SR_LOCK_VIOLATION = 1;
  localparam int SR_RESERVED = 0;
  localparam logic [7:0] SR_RESERVED_MASK = 8'hfe;
  localparam int LOCKED_BIT = 0;
  localparam int LOCKDOWN_BIT = 1;

  // Bus timing at 250 MHz
  localparam int CLK_PERIOD_PS = 4000;
  localparam int STROBE_NS = 60;
  localparam int ACCESS_NS = 80;
  localparam int RESET_PULSE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_CYC = (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;

  typedef enum logic [2:0] {
    OP_LOCK, OP_UNLOCK, OP_LOCKDOWN, OP_READ_LOCK, OP_READ_STATUS, OP_CLEAR_STATUS,
    OP_RESET, OP_NONE
  } flk_op_e;

  typedef struct packed {
    logic last;
    logic rd;
    logic plus2;
    logic [7:0] data;
  } flk_step_s;
endpackage

// file: flk_cyc_if.sv
// Carries one flash bus cycle request and its answer between sequencer and bus engine
interface flk_cyc_if;
  logic req;
  logic rd;
  logic [flk_pkg::ADDR_W-1:0] addr;
  logic [flk_pkg::DATA_W-1:0] wdata;
  logic done;
  logic [flk_pkg::DATA_W-1:0] rdata;
  modport seq (output req, output rd, output addr, output wdata, input done, input rdata);
  modport eng (input req, input rd, input addr, input wdata, output done, output rdata);
endinterface

// file: flk_cycle.sv
// Flash bus engine: runs one timed write or read cycle on the flash pins
module flk_cycle (
  input wire logic clk_i,
  input wire logic reset_i,
  flk_cyc_if.eng cyc,
  output logic [flk_pkg::ADDR_W-1:0] fl_addr_o,
  input wire logic [flk_pkg::DATA_W-1:0] fl_dq_i,
  output logic [flk_pkg::DATA_W-1:0] fl_dq_o,
  output logic fl_dq_oe_o,
  output logic fl_ce_n_o,
  output logic fl_oe_n_o,
  output logic fl_we_n_o
);
  import flk_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} flk_cst_e;
  typedef struct packed {
    flk_cst_e st;
    logic [CNT_W-1:0] cnt;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic done;
  } flk_cyc_s;

  flk_cyc_s r, next_r;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.st)
      C_IDLE: begin
        if (cyc.req) begin
          next_r.st = C_SETUP;
          next_r.rd = cyc.rd;
          next_r.addr = cyc.addr;
          next_r.wdata = cyc.wdata;
          next_r.ce_n = 1'b0;
          next_r.dq_oe = ~cyc.rd;
        end
      end
      C_SETUP: begin
        next_r.st = C_STROBE;
        next_r.cnt = r.rd ? CNT_W'(ACCESS_CYC - 1) : CNT_W'(STROBE_CYC - 1);
        next_r.oe_n = ~r.rd;
        next_r.we_n = r.rd;
      end
      C_STROBE: begin
        if (r.cnt == '0) begin
          // Sample at the end of the access window, before output enable rises
          if (r.rd) begin
            next_r.rdata = fl_dq_i;
          end
          next_r.oe_n = 1'b1;
          next_r.we_n = 1'b1;
          next_r.st = C_HOLD;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      C_HOLD: begin
        // Data and address held one cycle past the strobe edge
        next_r.ce_n = 1'b1;
        next_r.dq_oe = 1'b0;
        next_r.done = 1'b1;
        next_r.st = C_IDLE;
      end
      default: next_r.st = C_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
      r.st <= C_IDLE;
      r.ce_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.we_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign cyc.done = r.done;
  assign cyc.rdata = r.rdata;
  assign fl_addr_o = r.addr;
  assign fl_dq_o = r.wdata;
  assign fl_dq_oe_o = r.dq_oe;
  assign fl_ce_n_o = r.ce_n;
  assign fl_oe_n_o = r.oe_n;
  assign fl_we_n_o = r.we_n;
endmodule

// file: flk_ctrl.sv
// Host controller that locks, unlocks and inspects flash blocks through the flash pins
//
// Summary of operation
// - Host masks reserved status bit zero.
// - Lock: write 0x60 then 0x01.
// - Unlock: write 0x60 then 0xD0.
// - Lockdown: write 0x60 then 0x2F.
// - Identifier mode reads lock bits at +2.
// - Host trusts results only when ready.
module flk_ctrl (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic [flk_pkg::ADDR_W-1:0] fl_addr_o,
  input wire logic [flk_pkg::DATA_W-1:0] fl_dq_i,
  output logic [flk_pkg::DATA_W-1:0] fl_dq_o,
  output logic fl_dq_oe_o,
  output logic fl_ce_n_o,
  output logic fl_oe_n_o,
  output logic fl_we_n_o,
  output logic fl_wp_o,
  output logic fl_rst_n_o
);
  import flk_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_RESET} flk_sst_e;
  typedef struct packed {
    flk_sst_e st;
    flk_op_e op;
    logic [1:0] idx;
    logic [ADDR_W-1:0] block;
    logic wp;
    logic rst_n;
    logic [CNT_W-1:0] cnt;
    logic [1:0] lock_bits;
    logic [7:0] status;
    logic [31:0] rdata;
  } flk_ctl_s;

  flk_ctl_s r, next_r;
  flk_step_s step;

  // Both fail bits beside a ready engine mean the flash saw a bad command sequence
  function automatic logic seq_error(input logic [7:0] sr);
    return sr[SR_ENGINE_READY] & sr[SR_ERASE_FAIL] & sr[SR_PROGRAM_FAIL];
  endfunction

  // Each operation is a short list of bus cycles; the last one ends the sequence
  function automatic flk_step_s seq_step(input flk_op_e op, input logic [1:0] idx);
    flk_step_s s;
    s = '{last: 1'b0, rd: 1'b0, plus2: 1'b0, data: CMD_LOCK_SETUP};
    case (op)
      OP_LOCK: begin
        if (idx != 2'd0) begin
          s = '{last: 1'b1, rd: 1'b0, plus2: 1'b0, data: CMD_LOCK};
        end
      end
      OP_UNLOCK: begin
        if (idx != 2'd0) s = '{last: 1'b1, rd: 1'b0, plus2: 1'b0, data: CMD_UNLOCK};
      end
      OP_LOCKDOWN: begin
        if (idx != 2'd0) s = '{last: 1'b1, rd: 1'b0, plus2: 1'b0, data: CMD_LOCKDOWN};
      end
      OP_READ_LOCK: begin
        // Identifier mode is left again so later array reads are not confused
        case (idx)
          2'd0: s = '{last: 1'b0, rd: 1'b0, plus2: 1'b0, data: CMD_READ_ID};
          2'd1: s = '{last: 1'b0, rd: 1'b1, plus2: 1'b1, data: 8'h00};
          default: s = '{last: 1'b1, rd: 1'b0, plus2: 1'b0, data: CMD_READ_ARRAY};
        endcase
      end
      OP_READ_STATUS: begin
        if (idx == 2'd0) begin
          s = '{last: 1'b0, rd: 1'b0, plus2: 1'b0, data: CMD_READ_STATUS};
        end else begin
          s = '{last: 1'b1, rd: 1'b1, plus2: 1'b0, data: 8'h00};
        end
      end
      OP_CLEAR_STATUS: begin
        // Back to array mode so a stray read never returns status by surprise
        if (idx == 2'd0) begin
          s = '{last: 1'b0, rd: 1'b0, plus2: 1'b0, data: CMD_CLEAR_STATUS};
        end else begin
          s = '{last: 1'b1, rd: 1'b0, plus2: 1'b0, data: CMD_READ_ARRAY};
        end
      end
      default: s = '{last: 1'b1, rd: 1'b0, plus2: 1'b0, data: CMD_READ_ARRAY};
    endcase
    return s;
  endfunction

  flk_cyc_if cyc ();

  assign step = seq_step(r.op, r.idx);
  assign cyc.req = (r.st == S_ISSUE);
  assign cyc.rd = step.rd;
  assign cyc.addr = step.plus2 ? r.block + LOCK_STAT_OFS : r.block;
  assign cyc.wdata = {8'h00, step.data};

  always_comb begin
    next_r = r;
    next_r.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        CTRL_OFS: next_r.rdata = {29'h0, r.op};
        ADDR_OFS: next_r.rdata = {10'h000, r.block};
        STAT_OFS: begin
          next_r.rdata = '0;
          next_r.rdata[STAT_BUSY_BIT] = (r.st != S_IDLE);
          next_r.rdata[STAT_LOCK_LSB +: 2] = r.lock_bits;
          next_r.rdata[7:0] = r.status;
          next_r.rdata[STAT_LOCK_LSB + 2] = seq_error(r.status);
        end
        WP_OFS: next_r.rdata = {31'h0, r.wp};
        default: next_r.rdata = '0;
      endcase
    end
    if (wr_i) begin
      case (addr_i)
        ADDR_OFS: next_r.block = wdata_i[ADDR_W-1:0];
        WP_OFS: next_r.wp = wdata_i[0];
        default: ;
      endcase
    end
    case (r.st)
      S_IDLE: begin
        // A new order is only taken while idle; one in flight is never cut short
        if (wr_i && addr_i == CTRL_OFS && wdata_i[CTRL_GO_BIT]) begin
          next_r.op = flk_op_e'(wdata_i[2:0]);
          next_r.idx = 2'd0;
          if (flk_op_e'(wdata_i[2:0]) == OP_RESET) begin
            next_r.st = S_RESET;
            next_r.rst_n = 1'b0;
            next_r.cnt = CNT_W'(RESET_CYC - 1);
          end else if (flk_op_e'(wdata_i[2:0]) != OP_NONE) begin
            next_r.st = S_ISSUE;
          end
        end
      end
      S_ISSUE: next_r.st = S_WAIT;
      S_WAIT: begin
        if (cyc.done) begin
          next_r.st = S_ISSUE;
          if (r.op == OP_READ_LOCK && step.rd) begin
            next_r.lock_bits = {cyc.rdata[LOCKDOWN_BIT], cyc.rdata[LOCKED_BIT]};
          end
          if (r.op == OP_READ_STATUS && step.rd) begin
            next_r.status = cyc.rdata[7:0] & SR_RESERVED_MASK;
          end
          if (r.op == OP_READ_STATUS && step.rd && !cyc.rdata[SR_ENGINE_READY]) begin
            // Still busy: result bits are not trusted yet, so read again
            next_r.idx = r.idx;
          end else if (step.last) begin
            next_r.st = S_IDLE;
          end else begin
            next_r.idx = r.idx + 2'd1;
          end
        end
      end
      S_RESET: begin
        // Pulsing the flash reset returns every block to plain locked
        if (r.cnt == '0) begin
          next_r.rst_n = 1'b1;
          next_r.lock_bits = 2'b01;
          next_r.st = S_IDLE;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      default: next_r.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
      r.st <= S_IDLE;
      r.op <= OP_NONE;
      r.rst_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  flk_cycle u_cycle (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .cyc(cyc.eng),
    .fl_addr_o(fl_addr_o),
    .fl_dq_i(fl_dq_i),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe_o(fl_dq_oe_o),
    .fl_ce_n_o(fl_ce_n_o),
    .fl_oe_n_o(fl_oe_n_o),
    .fl_we_n_o(fl_we_n_o)
  );

  assign rdata_o = r.rdata;
  assign fl_wp_o = r.wp;
  assign fl_rst_n_o = r.rst_n;
endmodule

// file: flk_ctrl_checker.sv
// Port-level timing checks for the flash lock controller
module flk_ctrl_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [flk_pkg::ADDR_W-1:0] fl_addr_o,
  input wire logic [flk_pkg::DATA_W-1:0] fl_dq_o,
  input wire logic fl_dq_oe_o,
  input wire logic fl_ce_n_o,
  input wire logic fl_oe_n_o,
  input wire logic fl_we_n_o,
  input wire logic fl_rst_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside read");
  a_we_in_ce: assert property (!fl_we_n_o |-> !fl_ce_n_o && fl_dq_oe_o)
    else $error("write strobe outside chip enable");
  a_strobe_excl: assert property (!(!fl_oe_n_o && !fl_we_n_o))
    else $error("both strobes low");
  a_we_width: assert property ($fell(fl_we_n_o) |->
    (!fl_we_n_o)[*8] ##1 (!fl_we_n_o)[*7] ##1 fl_we_n_o)
    else $error("write strobe width wrong");
  a_write_stable: assert property (!fl_we_n_o && $past(!fl_we_n_o) |->
    $stable(fl_dq_o) && $stable(fl_addr_o))
    else $error("write data moved during strobe");
  a_read_released: assert property (!fl_oe_n_o |-> !fl_dq_oe_o && !fl_ce_n_o)
    else $error("data driven during read");
  a_oe_width: assert property ($fell(fl_oe_n_o) |->
    (!fl_oe_n_o)[*8] ##1 (!fl_oe_n_o)[*8] ##1 (!fl_oe_n_o)[*4] ##1 fl_oe_n_o)
    else $error("read strobe width wrong");
  a_rst_width: assert property ($fell(fl_rst_n_o) |-> ##24 !fl_rst_n_o ##1 fl_rst_n_o)
    else $error("flash reset width wrong");
  a_cmd_high_zero: assert property ($fell(fl_we_n_o) |-> fl_dq_o[15:8] == 8'h00)
    else $error("command high byte not zero");
  c_write: cover property ($fell(fl_we_n_o));
  c_read: cover property ($fell(fl_oe_n_o));
  c_reset: cover property ($fell(fl_rst_n_o));
endmodule

// file: flk_flash_model.sv
// Behavioural flash device: block lock bits and status word, four blocks
module flk_flash_model (
  input wire logic clk_i,
  input wire logic [21:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic wp_i,
  input wire logic rst_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] lk [4];
  logic [7:0] sr;
  logic [1:0] mode;
  logic setup, we_q, wp_q;
  logic [15:0] last, val;
  logic [1:0] idx;
  assign idx = addr_i[17:16];
  // Reserved bit reads as 1 so the controller's masking is exercised
  assign val = (mode == 2'd2) ? ((addr_i[15:0] == 16'h2) ? {14'h0, lk[idx]} : 16'h0)
    : (mode == 2'd1) ? {8'h0, sr | 8'h01} : 16'hffff;
  // A released bus shows the inverse of its last value, never a stale copy
  assign dq_o = (!ce_n_i && !oe_n_i) ? val : ~last;
  always @(posedge clk_i) begin
    we_q <= we_n_i;
    wp_q <= wp_i;
    if (!ce_n_i && !oe_n_i) last <= val;
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) lk[i] <= 2'b01;
      // Write engine is not modelled: both fail bits set only on a bad command after 0x60; suspend, supply and violation bits stay clear
      sr <= 8'h80;
      mode <= 2'd0;
      setup <= 1'b0;
    end else if (we_n_i && !we_q && !ce_n_i) begin
      if (setup) begin
        setup <= 1'b0;
        case (dq_i[7:0])
          8'h01: lk[idx][0] <= 1'b1;
          8'hd0: if (!(lk[idx][1] && !wp_i)) lk[idx][0] <= 1'b0;
          8'h2f: lk[idx] <= 2'b11;
          default: sr[5:4] <= 2'b11;
        endcase
      end else begin
        case (dq_i[7:0])
          8'h60: setup <= 1'b1;
          8'h90: mode <= 2'd2;
          8'h70: mode <= 2'd1;
          8'h50: sr[5:1] <= 5'h0;
          default: mode <= 2'd0;
        endcase
      end
    end else if (wp_q && !wp_i) begin
      for (int i = 0; i < 4; i++) if (lk[i][1]) lk[i][0] <= 1'b1;
    end
  end
  initial begin
    last = 16'h0;
    we_q = 1'b1;
    wp_q = 1'b0;
  end
endmodule

// file: testbench.sv
// Self-checking bench for the flash lock controller against a flash model
bind flk_ctrl flk_ctrl_checker chk (.clk_i(clk_i), .reset_i(reset_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o),
  .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o),
  .fl_rst_n_o(fl_rst_n_o));
module testbench;
  import flk_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  logic [ADDR_W-1:0] fa;
  logic [DATA_W-1:0] fdi, fdo;
  logic oe, ce_n, oe_n, we_n, wp, rst_n, cur_wp;
  logic [1:0] exp_lk [4];
  int err_count = 0, n_compared = 0, cycles = 0, b, op;
  flk_ctrl dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fl_addr_o(fa), .fl_dq_i(fdi),
    .fl_dq_o(fdo), .fl_dq_oe_o(oe), .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n), .fl_we_n_o(we_n),
    .fl_wp_o(wp), .fl_rst_n_o(rst_n));
  flk_flash_model flash (.clk_i(clk_i), .addr_i(fa), .dq_i(fdo), .dq_o(fdi), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .wp_i(wp), .rst_n_i(rst_n));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      complete_run();
    end
  end
  function automatic logic [1:0] next_lock(logic [1:0] c, int o, logic w);
    case (o)
      0: return c | 2'b01;
      1: return (c[1] && !w) ? c : {c[1], 1'b0};
      2: return 2'b11;
      default: return c;
    endcase
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic run_op(int o);
    wr(CTRL_OFS, 32'h10 | o);
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 300; i++) begin
      rd(STAT_OFS);
      if (d[STAT_BUSY_BIT] === 1'b0) break;
    end
    chk("busy", 32'h0, {31'h0, d[STAT_BUSY_BIT]});
  endtask
  task automatic lock_op(int blk, int o);
    wr(ADDR_OFS, blk << 16);
    run_op(o);
    if (o < 3) exp_lk[blk] = next_lock(exp_lk[blk], o, cur_wp);
    run_op(3);
    chk("lock bits", {30'h0, exp_lk[blk]}, {30'h0, d[9:8]});
  endtask
  task automatic set_wp(logic v);
    wr(WP_OFS, {31'h0, v});
    if (cur_wp && !v) for (int i = 0; i < 4; i++) if (exp_lk[i][1]) exp_lk[i][0] = 1'b1;
    cur_wp = v;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    void'($urandom(78185));
    cur_wp = 1'b0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(CTRL_OFS);
    chk("ctrl reset", 32'h7, d);
    rd(4'h2);
    chk("unmapped", 32'h0, d);
    wr(ADDR_OFS, 32'hffffffff);
    rd(ADDR_OFS);
    chk("addr reg", 32'h003fffff, d);
    $display("test registers done");
    run_op(6);
    for (int i = 0; i < 4; i++) exp_lk[i] = 2'b01;
    for (int i = 0; i < 4; i++) lock_op(i, 3);
    lock_op(0, 2);
    lock_op(0, 1);
    set_wp(1'b1);
    lock_op(0, 1);
    set_wp(1'b0);
    lock_op(0, 3);
    $display("test lockdown done");
    for (int i = 0; i < 24; i++) begin
      b = $urandom % 4;
      op = $urandom % 3;
      if ($urandom % 4 == 0) set_wp(~cur_wp);
      lock_op(b, op);
    end
    $display("test random done");
    run_op(4);
    chk("status", 32'h80, {23'h0, d[10], d[7:0]});
    run_op(5);
    run_op(6);
    for (int i = 0; i < 4; i++) exp_lk[i] = 2'b01;
    for (int i = 0; i < 4; i++) lock_op(i, 3);
    $display("test reset done");
    complete_run();
  end
endmodule
